// *** design/clk_mode_map.svh ***
// Register offsets, field positions, reset values and codes of the mode block
`ifndef CLK_MODE_MAP_SVH
`define CLK_MODE_MAP_SVH
`define OFF_LINK_CLOCKING_CONFIG 8'h03
`define OFF_LEGACY_FORMAT        8'h04
`define OFF_DIV_CFG              8'h06
`define OFF_DIV_N                8'h07
`define OFF_PARALLEL_COMPAT_CFG  8'h10
`define OFF_COMPAT_DATATYPE      8'h11
`define MODE_FIELD_MSB           2
`define MODE_OVERRIDE_BIT        4
`define DIV_M_MSB                4
`define DIV_POST_LSB             5
`define DIV_POST_MSB             7
`define MATCH_EN_BIT             7
`define POSTDIV_CODE_RST         3'h2
`define DIV_M_RST                5'h01
`define DIV_N_RST                8'h01
`define LEGACY_FMT_RST           8'h00
`define COMPAT_CFG_RST           8'h00
`define COMPAT_DT_RST            8'h00
`define ADDR_PRIMARY             7'h30
`define ADDR_SECONDARY           7'h32
`define FMT_RAW10                2'h0
`define FMT_RAW12_HF             2'h1
`endif

// *** design/clk_mode_pkg.sv ***
// Types shared by the clocking mode block
`default_nettype none
package clk_mode_pkg;
    typedef enum logic [2:0] {
        MODE_SYNC       = 3'h0,
        MODE_NONSYNC_EXT = 3'h2,
        MODE_NONSYNC_INT = 3'h3,
        MODE_LEGACY     = 3'h5
    } op_mode_t;
    typedef enum logic [1:0] {
        REF_BACK_CHANNEL,
        REF_EXT_CLOCK,
        REF_ALWAYS_ON,
        REF_NONE
    } ref_src_t;
endpackage
`default_nettype wire

// *** design/clk_mode_select.sv ***
// Clocking mode selection, mode register set and reference clock divider
`include "clk_mode_map.svh"
`default_nettype none

module clk_mode_select #(
    parameter int DIV_W = 13
) (
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       sys_rst_in,
    // Pins and straps
    input  wire logic       power_down_input_in,
    input  wire logic [2:0] mode_strap_in,
    input  wire logic       address_strap_pin_in,
    input  wire logic       forward_link_rate_in,
    // Register port
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    // Packet filter
    input  wire logic [5:0] pkt_dtype_in,
    output logic            pkt_forward_out,
    // Mode and clock outputs
    output logic      [2:0] op_mode_out,
    output logic      [1:0] ref_src_out,
    output logic      [1:0] pixel_fmt_out,
    output logic      [6:0] target_addr_out,
    output logic            ref_clk_out,
    output logic            ref_clk_oe_out
);
    initial begin
        if (DIV_W < 9 || DIV_W > 16)
            $error("DIV_W out of range");
    end

    logic       pd_prev_reg;
    logic       active_reset;
    logic       pd_rise;
    logic [2:0] mode_reg;
    logic       override_reg;
    logic [7:0] fmt_reg;
    logic [7:0] cfg_reg;
    logic [7:0] dt_reg;
    logic [7:0] div_mp_reg;
    logic [7:0] div_n_reg;
    logic [DIV_W-1:0] acc_reg;
    logic [DIV_W-1:0] acc_next;
    logic [DIV_W-1:0] period;
    logic       clk_en;
    logic [2:0] wmode;
    logic       wmode_ok;

    // Power-down low acts as a second reset for the mode logic
    assign active_reset = sys_rst_in || !power_down_input_in;
    assign pd_rise = power_down_input_in && !pd_prev_reg;
    assign wmode = reg_wdata_in[`MODE_FIELD_MSB:0];
    // Unlisted codes are refused on software writes; the strap path still loads any code
    assign wmode_ok = (wmode == clk_mode_pkg::MODE_SYNC) ||
                      (wmode == clk_mode_pkg::MODE_NONSYNC_EXT) ||
                      (wmode == clk_mode_pkg::MODE_NONSYNC_INT) ||
                      (wmode == clk_mode_pkg::MODE_LEGACY);

    // Edge detector on the power-down control
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in)
            pd_prev_reg <= 1'b0;
        else
            pd_prev_reg <= power_down_input_in;
    end

    // Mode field: strap on release, software only when unlocked
    always_ff @(posedge core_clk_in) begin
        if (active_reset) begin
            mode_reg     <= 3'h0;
            override_reg <= 1'b0;
        end else if (pd_rise) begin
            mode_reg     <= mode_strap_in;
            override_reg <= 1'b0;
        end else if (reg_wr_in &&
                     reg_addr_in == `OFF_LINK_CLOCKING_CONFIG) begin
            // Unlock takes effect from the next write, not this one
            override_reg <= reg_wdata_in[`MODE_OVERRIDE_BIT];
            if (override_reg && wmode_ok)
                mode_reg <= wmode;
        end
    end

    // Configuration registers for divider and legacy packing
    always_ff @(posedge core_clk_in) begin
        if (active_reset) begin
            fmt_reg    <= `LEGACY_FMT_RST;
            cfg_reg    <= `COMPAT_CFG_RST;
            dt_reg     <= `COMPAT_DT_RST;
            div_mp_reg <= {`POSTDIV_CODE_RST, `DIV_M_RST};
            div_n_reg  <= `DIV_N_RST;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                `OFF_LEGACY_FORMAT:
                    fmt_reg <= reg_wdata_in;
                `OFF_PARALLEL_COMPAT_CFG:
                    cfg_reg <= reg_wdata_in;
                `OFF_COMPAT_DATATYPE:     dt_reg     <= reg_wdata_in;
                `OFF_DIV_CFG:             div_mp_reg <= reg_wdata_in;
                `OFF_DIV_N:               div_n_reg  <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // Read data: mode field always the live mode
    always_ff @(posedge core_clk_in) begin
        if (active_reset)
            reg_rdata_out <= 8'h00;
        else if (reg_rd_in) begin
            unique case (reg_addr_in)
                `OFF_LINK_CLOCKING_CONFIG:
                    reg_rdata_out <= {3'h0, override_reg, 1'b0,
                                      mode_reg};
                `OFF_LEGACY_FORMAT:       reg_rdata_out <= fmt_reg;
                `OFF_PARALLEL_COMPAT_CFG: reg_rdata_out <= cfg_reg;
                `OFF_COMPAT_DATATYPE:     reg_rdata_out <= dt_reg;
                `OFF_DIV_CFG:             reg_rdata_out <= div_mp_reg;
                `OFF_DIV_N:               reg_rdata_out <= div_n_reg;
                default:                  reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // Mode decode, pixel format and address straps
    always_ff @(posedge core_clk_in) begin
        if (active_reset) begin
            op_mode_out     <= 3'h0;
            ref_src_out     <= clk_mode_pkg::REF_NONE;
            pixel_fmt_out   <= `FMT_RAW10;
            target_addr_out <= `ADDR_PRIMARY;
        end else begin
            op_mode_out <= mode_reg;
            unique case (mode_reg)
                clk_mode_pkg::MODE_SYNC:
                    ref_src_out <= clk_mode_pkg::REF_BACK_CHANNEL;
                clk_mode_pkg::MODE_NONSYNC_EXT:
                    ref_src_out <= clk_mode_pkg::REF_EXT_CLOCK;
                clk_mode_pkg::MODE_NONSYNC_INT:
                    ref_src_out <= clk_mode_pkg::REF_ALWAYS_ON;
                clk_mode_pkg::MODE_LEGACY:
                    ref_src_out <= clk_mode_pkg::REF_EXT_CLOCK;
                default:
                    ref_src_out <= clk_mode_pkg::REF_NONE;
            endcase
            // Only raw10 and the high-rate raw12 exist here
            pixel_fmt_out <= fmt_reg[0] ?
                             `FMT_RAW12_HF : `FMT_RAW10;
            if (pd_rise)
                target_addr_out <= address_strap_pin_in ?
                                   `ADDR_SECONDARY : `ADDR_PRIMARY;
        end
    end

    // Packet filter on the datatype value
    always_ff @(posedge core_clk_in) begin
        if (active_reset)
            pkt_forward_out <= 1'b0;
        else
            pkt_forward_out <= !dt_reg[`MATCH_EN_BIT] ||
                               (pkt_dtype_in == dt_reg[5:0]);
    end

    // Divider period P*N; M steps the accumulator per link enable
    // Product fits 16 bits for any post code and N; cut to DIV_W on purpose
    assign period = DIV_W'(
        ({13'h0, 3'h1} << div_mp_reg[`DIV_POST_MSB:`DIV_POST_LSB])
        * {8'h0, div_n_reg});
    // Internal oscillator mode must leave the sensor pin quiet
    assign clk_en = (mode_reg !=
                     clk_mode_pkg::MODE_NONSYNC_INT);
    always_comb begin
        acc_next = acc_reg + DIV_W'(div_mp_reg[`DIV_M_MSB:0]);
        if (acc_next >= period)
            acc_next = acc_next - period;
    end

    // Fractional divider; output toggles on each wrap for half period
    always_ff @(posedge core_clk_in) begin
        if (active_reset || !clk_en) begin
            acc_reg        <= '0;
            ref_clk_out    <= 1'b0;
            ref_clk_oe_out <= 1'b0;
        end else begin
            ref_clk_oe_out <= 1'b1;
            if (forward_link_rate_in) begin
                acc_reg <= acc_next;
                if (acc_reg + DIV_W'(div_mp_reg[`DIV_M_MSB:0]) >= period)
                    ref_clk_out <= ~ref_clk_out;
            end
        end
    end

    // Checks on the mode field
    mode_lock_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        (reg_wr_in && reg_addr_in == `OFF_LINK_CLOCKING_CONFIG &&
         !override_reg && !pd_rise) |=> $stable(mode_reg))
        else $error("locked mode field changed");
    mode_write_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        (reg_wr_in && reg_addr_in == `OFF_LINK_CLOCKING_CONFIG &&
         override_reg && wmode_ok && !pd_rise) |=>
        mode_reg == $past(wmode))
        else $error("unlocked mode write lost");
    strap_latch_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        pd_rise |=> mode_reg == $past(mode_strap_in))
        else $error("strap not latched");
    mode_read_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        (reg_rd_in && reg_addr_in == `OFF_LINK_CLOCKING_CONFIG) |=>
        reg_rdata_out[2:0] == $past(mode_reg))
        else $error("mode readback wrong");
    mode_out_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        1'b1 |=> op_mode_out == $past(mode_reg))
        else $error("mode output lags wrongly");

    // Checks on the source decode
    sync_src_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        (mode_reg == clk_mode_pkg::MODE_SYNC) |=>
        ref_src_out == clk_mode_pkg::REF_BACK_CHANNEL)
        else $error("sync source wrong");
    ext_src_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        (mode_reg == clk_mode_pkg::MODE_NONSYNC_EXT) |=>
        ref_src_out == clk_mode_pkg::REF_EXT_CLOCK)
        else $error("external source wrong");
    int_src_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        (mode_reg == clk_mode_pkg::MODE_NONSYNC_INT) |=>
        ref_src_out == clk_mode_pkg::REF_ALWAYS_ON)
        else $error("internal source wrong");
    legacy_src_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        (mode_reg == clk_mode_pkg::MODE_LEGACY) |=>
        ref_src_out == clk_mode_pkg::REF_EXT_CLOCK)
        else $error("legacy source wrong");

    // Checks on the reference output
    int_osc_off_a: assert property (
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (mode_reg == clk_mode_pkg::MODE_NONSYNC_INT) |=> !ref_clk_oe_out)
        else $error("output on in internal mode");
    pd_low_off_a: assert property (
        @(posedge core_clk_in)
        !power_down_input_in |=> !ref_clk_oe_out)
        else $error("output driven in power-down");
    ext_on_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        (mode_reg == clk_mode_pkg::MODE_NONSYNC_EXT) [*2] |-> ref_clk_oe_out)
        else $error("output off in external mode");
    sync_on_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        (mode_reg == clk_mode_pkg::MODE_SYNC) [*2] |-> ref_clk_oe_out)
        else $error("output off in sync mode");
    wrap_toggle_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        (clk_en && forward_link_rate_in &&
         acc_reg + DIV_W'(div_mp_reg[`DIV_M_MSB:0]) >= period) |=>
        ref_clk_out != $past(ref_clk_out))
        else $error("divider wrap without toggle");
    post_rst_a: assert property (
        @(posedge core_clk_in)
        sys_rst_in |=>
        div_mp_reg[`DIV_POST_MSB:`DIV_POST_LSB] == `POSTDIV_CODE_RST)
        else $error("post divider reset wrong");

    // Checks on straps, format and legacy registers
    addr_strap_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        pd_rise |=> target_addr_out == ($past(address_strap_pin_in) ?
                                        `ADDR_SECONDARY : `ADDR_PRIMARY))
        else $error("target address strap lost");
    fmt_raw_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        1'b1 |=> pixel_fmt_out == ($past(fmt_reg[0]) ?
                                   `FMT_RAW12_HF : `FMT_RAW10))
        else $error("pixel format wrong");
    fmt_write_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        (reg_wr_in && reg_addr_in == `OFF_LEGACY_FORMAT) |=>
        fmt_reg == $past(reg_wdata_in))
        else $error("format override write lost");
    cfg_write_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        (reg_wr_in && reg_addr_in == `OFF_PARALLEL_COMPAT_CFG) |=>
        cfg_reg == $past(reg_wdata_in))
        else $error("packing config write lost");
    filter_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        (dt_reg[`MATCH_EN_BIT] && pkt_dtype_in == dt_reg[5:0]) |=>
        pkt_forward_out)
        else $error("matching packet dropped");
    filter_miss_a: assert property (
        @(posedge core_clk_in) disable iff (active_reset)
        (dt_reg[`MATCH_EN_BIT] && pkt_dtype_in != dt_reg[5:0]) |=>
        !pkt_forward_out)
        else $error("mismatching packet forwarded");
endmodule
`default_nettype wire

// *** verification/link_sensor_model.sv ***
// Far side model: link rate ticks and a sensor counting its clock edges
`default_nettype none
module link_sensor_model #(
    parameter int TICK_GAP = 2
) (
    // Clock and counter clear
    input  wire logic        core_clk_in,
    input  wire logic        clear_in,
    // Link side
    output logic             tick_out,
    // Sensor side
    input  wire logic        ref_clk_in,
    input  wire logic        ref_oe_in,
    output logic      [15:0] edge_count_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int   gap_cnt  = 0;
    logic last_clk = 1'b0;
    // One tick pulse every TICK_GAP cycles, changed off the sampling edge
    always @(negedge core_clk_in) begin
        gap_cnt = (gap_cnt + 1) % TICK_GAP;
        tick_out <= (gap_cnt == 0);
    end
    // Edges only count while driven; an undriven pin is just noise
    always @(posedge core_clk_in) begin
        if (clear_in)
            edge_count_out <= 16'h0000;
        else if (ref_oe_in && ref_clk_in !== last_clk)
            edge_count_out <= edge_count_out + 16'h0001;
        last_clk <= ref_clk_in;
    end
endmodule
`default_nettype wire

// *** verification/clocking_mode_select_refclk_out_tb_top.sv ***
// Self-checking bench for the clocking mode and reference clock block
`default_nettype none
module clocking_mode_select_refclk_out_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst = 1, pwr_up = 0, a_strap = 0;
    logic        wr = 0, rd = 0, clr = 0, fwd, rclk, roe, tick;
    logic [2:0]  strap = 3'h0, mode;
    logic [1:0]  src, fmt;
    logic [6:0]  taddr;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, v, d;
    logic [5:0]  dtype = 6'h00;
    logic [15:0] cnt;
    logic [2:0]  modes [4] = '{3'h2, 3'h3, 3'h5, 3'h0};
    int          fail_count = 0, n_checks = 0, e;
    // Free-running 100 MHz clock
    always #5 clk = ~clk;
    clk_mode_select DUT (.core_clk_in(clk), .sys_rst_in(rst),
        .power_down_input_in(pwr_up), .mode_strap_in(strap),
        .address_strap_pin_in(a_strap), .forward_link_rate_in(tick),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .pkt_dtype_in(dtype), .pkt_forward_out(fwd), .op_mode_out(mode),
        .ref_src_out(src), .pixel_fmt_out(fmt), .target_addr_out(taddr),
        .ref_clk_out(rclk), .ref_clk_oe_out(roe));
    link_sensor_model FAR (.core_clk_in(clk), .clear_in(clr),
        .tick_out(tick), .ref_clk_in(rclk), .ref_oe_in(roe),
        .edge_count_out(cnt));
    // Compare one value and count it
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Register write, strobe held for one edge, then one idle edge
    task automatic wr_reg(input logic [7:0] a, dat);
        wr = 1'b1;
        addr = a;
        wdata = dat;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask
    // Register read, data taken one edge after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] dat);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        dat = rdata;
        @(negedge clk);
    endtask
    // Power-down pulse latching new straps; outputs settle two edges later
    task automatic power_cycle(input logic [2:0] s, input logic a);
        pwr_up = 1'b0; strap = s; a_strap = a;
        @(negedge clk);
        pwr_up = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    // Expected reference source of a mode code
    function automatic logic [1:0] src_of(input logic [2:0] m);
        case (m)
            3'h0: return 2'h0;
            3'h3: return 2'h2;
            default: return 2'h1;
        endcase
    endfunction
    task automatic summarize;
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        fail_count++;
        summarize();
    end
    // Main sequence
    initial begin
        void'($urandom(32'h23050fc7));
        repeat (3) @(negedge clk);
        chk("src in reset", {6'h00, src}, 8'h03);
        chk("addr in reset", {1'b0, taddr}, 8'h30);
        rst = 1'b0;
        power_cycle(3'h0, 1'b0);
        rd_reg(8'h06, v); chk("div cfg reset", v, 8'h41);
        rd_reg(8'h07, v); chk("div n reset", v, 8'h01);
        // The four listed strap modes, address strap alternating 0 and 1
        for (int i = 0; i < 4; i++) begin
            power_cycle(modes[i], i[0]);
            chk("strap mode", {5'h00, mode}, {5'h00, modes[i]});
            rd_reg(8'h03, v); chk("mode field", v, {5'h00, modes[i]});
            chk("ref src", {6'h00, src}, {6'h00, src_of(modes[i])});
            chk("ref oe", {7'h00, roe}, {7'h00, modes[i] != 3'h3});
            chk("target", {1'b0, taddr}, i[0] ? 8'h32 : 8'h30);
        end
        // Mode writes: locked, then override, invalid, internal
        wr_reg(8'h03, 8'h03);
        rd_reg(8'h03, v); chk("locked mode", v, 8'h00);
        wr_reg(8'h03, 8'h10);
        wr_reg(8'h03, 8'h15);
        rd_reg(8'h03, v); chk("forced legacy", v, 8'h15);
        chk("legacy out", {5'h00, mode}, 8'h05);
        wr_reg(8'h03, 8'h17);
        rd_reg(8'h03, v); chk("bad code", v, 8'h15);
        wr_reg(8'h05, 8'h08);
        wr_reg(8'h03, 8'h13);
        repeat (2) @(negedge clk);
        chk("int mode", {5'h00, mode}, 8'h03);
        chk("int oe", {7'h00, roe}, 8'h00);
        wr_reg(8'h03, 8'h10);
        // Divider table: post code, M, N
        for (int k = 0; k < 3; k++) begin
            v = (k == 1) ? 8'h62 : 8'h41;
            wr_reg(8'h06, v);
            wr_reg(8'h07, (k == 2) ? 8'h02 : 8'h01);
            clr = 1'b1;
            @(negedge clk);
            clr = 1'b0;
            repeat (160) @(negedge clk);
            e = 80 * v[4:0] / ((1 << v[7:5]) * ((k == 2) ? 2 : 1));
            chk("ref edges", {7'h00, (cnt + 1 >= e && cnt <= e + 1)}, 8'h01);
        end
        // Random legacy registers and filter
        d = 8'($urandom());
        wr_reg(8'h04, d);
        rd_reg(8'h04, v); chk("fmt reg", v, d);
        chk("pixel fmt", {6'h00, fmt}, {7'h00, d[0]});
        d = 8'($urandom());
        wr_reg(8'h10, d);
        rd_reg(8'h10, v); chk("compat cfg", v, d);
        dtype = 6'($urandom());
        wr_reg(8'h11, {2'h2, dtype});
        rd_reg(8'h11, v); chk("dt reg", v, {2'h2, dtype});
        @(negedge clk);
        chk("dt match", {7'h00, fwd}, 8'h01);
        dtype = dtype ^ 6'h01;
        repeat (2) @(negedge clk);
        chk("dt miss", {7'h00, fwd}, 8'h00);
        rd_reg(8'h3f, v); chk("unmapped", v, 8'h00);
        pwr_up = 1'b0;
        repeat (2) @(negedge clk);
        chk("pd oe", {7'h00, roe}, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
